// ---- src/lusr_map.vh ----
// Purpose: Register map, field positions and reset values for the
//          line unit status and pulse shape register slice.
// Assumes: AXI4-Lite with 32-bit data, one register per aligned word.
// Notes:   Byte address is four times the register index.
`ifndef LUSR_MAP_VH
`define LUSR_MAP_VH

`define LUSR_ADDR_W 16
`define LUSR_IDX_STATUS 14'h0f06
`define LUSR_IDX_CABLE 14'h0f07
`define LUSR_IDX_SEG1 14'h0f08
`define LUSR_IDX_SEG2 14'h0f09
`define LUSR_IDX_MASK 14'h0f10
`define LUSR_IDX_CTRL 14'h0f11
`define LUSR_IDX_LIVE 14'h0f12

`define LUSR_BIT_PAT 0
`define LUSR_BIT_LOS 1
`define LUSR_BIT_UNUSED 2
`define LUSR_BIT_LOOP 3

`define LUSR_CTRL_RAIL 0
`define LUSR_CTRL_EQ_LO 1
`define LUSR_CTRL_EQ_HI 5

`define LUSR_RST_SEG 7'h00
`define LUSR_RST_MASK 8'h00
`define LUSR_RST_CABLE 6'h00
`define LUSR_RST_EQ 5'h00
`define LUSR_EQ_ARB_CODE 5'h1f

`define LUSR_RESP_OKAY 2'h0
`define LUSR_RESP_SLVERR 2'h2

`endif

// ---- src/lusr_change_flag.v ----
// Purpose: One sticky change-of-state flag.
// Assumes: Live input synchronous to core_clk.
// Notes:   Set wins over any clear in the same cycle.
`timescale 1ns/10ps
`default_nettype none
module lusr_change_flag (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    input wire clk_en,
    // Control
    input wire live,
    input wire arm,
    input wire rd_clr,
    input wire wr_clr,
    // Result
    output reg flag_reg
);
    reg prev_reg;
    wire changed;
    wire flag_next;

    // Previous value tracks even when disarmed, so arming raises nothing stale
    assign changed = arm & (live ^ prev_reg);
    assign flag_next = changed | (flag_reg & ~(rd_clr | wr_clr));

    always @(posedge core_clk) begin
        if (sys_rst) begin
            prev_reg <= 1'b0;
            flag_reg <= 1'b0;
        end else if (clk_en) begin
            prev_reg <= live;
            flag_reg <= flag_next;
        end
    end
endmodule // lusr_change_flag
`default_nettype wire

// ---- src/lusr_axil_slave.v ----
// Purpose: AXI4-Lite slave front end producing register strobes.
// Assumes: One outstanding write and one outstanding read.
// Notes:   Write answers one edge after both halves are held.
`timescale 1ns/10ps
`default_nettype none
`include "lusr_map.vh"
module lusr_axil_slave (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    input wire clk_en,
    // AXI4-Lite write
    input wire [15:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [15:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Register side
    output wire wr_stb,
    output reg [15:0] wr_addr,
    output reg [7:0] wr_data,
    output reg wr_lane,
    input wire wr_hit,
    output wire rd_stb,
    output wire [15:0] rd_addr,
    input wire [7:0] rd_data,
    input wire rd_hit
);
    reg aw_full;
    reg w_full;

    assign s_axi_awready = clk_en & ~aw_full & ~s_axi_bvalid;
    assign s_axi_wready = clk_en & ~w_full & ~s_axi_bvalid;
    assign s_axi_arready = clk_en & ~s_axi_rvalid;
    assign wr_stb = clk_en & aw_full & w_full & ~s_axi_bvalid;
    assign rd_stb = s_axi_arvalid & s_axi_arready;
    assign rd_addr = s_axi_araddr;

    always @(posedge core_clk) begin
        if (sys_rst) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            wr_addr <= 16'h0000;
            wr_data <= 8'h00;
            wr_lane <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LUSR_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `LUSR_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_full <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_full <= 1'b1;
                wr_data <= s_axi_wdata[7:0];
                wr_lane <= s_axi_wstrb[0];
            end
            if (wr_stb) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `LUSR_RESP_OKAY : `LUSR_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_stb) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_data};
                s_axi_rresp <= rd_hit ? `LUSR_RESP_OKAY : `LUSR_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // lusr_axil_slave
`default_nettype wire

// ---- src/lusr_regs.v ----
// Purpose: Line unit change flags, cable loss readout and first two
//          arbitrary pulse segments, reached over AXI4-Lite.
// Assumes: Live status inputs synchronous to core_clk.
// Notes:   Status reads clear flags; writing ones clears them too.
`timescale 1ns/10ps
`default_nettype none
`include "lusr_map.vh"
module lusr_regs (
    // Clock, reset, enable
    input wire core_clk,
    input wire sys_rst,
    input wire clk_en,
    // AXI4-Lite write
    input wire [15:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [15:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // Live line status
    input wire loop_code_detect_state,
    input wire signal_loss_state,
    input wire pattern_lock_state,
    input wire [5:0] cable_attenuation_code,
    // Transmit pulse shaping
    output reg arb_mode_active,
    output reg [7:0] pulse_amplitude_first,
    output reg [7:0] pulse_amplitude_second,
    output reg [4:0] equalizer_select_field,
    output reg single_rail_sel,
    // Interrupt
    output wire irq
);
    localparam [2:0] SEL_NONE = 3'd0;
    localparam [2:0] SEL_STATUS = 3'd1;
    localparam [2:0] SEL_CABLE = 3'd2;
    localparam [2:0] SEL_SEG1 = 3'd3;
    localparam [2:0] SEL_SEG2 = 3'd4;
    localparam [2:0] SEL_MASK = 3'd5;
    localparam [2:0] SEL_CTRL = 3'd6;
    localparam [2:0] SEL_LIVE = 3'd7;

    // Word-aligned decode; misaligned addresses miss
    function [2:0] reg_sel;
        input [15:0] a;
        begin
            if (a[1:0] != 2'b00) begin
                reg_sel = SEL_NONE;
            end else begin
                case (a[15:2])
                    `LUSR_IDX_STATUS: reg_sel = SEL_STATUS;
                    `LUSR_IDX_CABLE: reg_sel = SEL_CABLE;
                    `LUSR_IDX_SEG1: reg_sel = SEL_SEG1;
                    `LUSR_IDX_SEG2: reg_sel = SEL_SEG2;
                    `LUSR_IDX_MASK: reg_sel = SEL_MASK;
                    `LUSR_IDX_CTRL: reg_sel = SEL_CTRL;
                    `LUSR_IDX_LIVE: reg_sel = SEL_LIVE;
                    default: reg_sel = SEL_NONE;
                endcase
            end
        end
    endfunction

    // Signed magnitude to two's complement for the pulse DAC
    function [7:0] sm_to_twos;
        input [6:0] sm;
        reg [7:0] mag;
        begin
            mag = {2'b00, sm[5:0]};
            if (sm[6]) begin
                sm_to_twos = 8'h00 - mag;
            end else begin
                sm_to_twos = mag;
            end
        end
    endfunction

    // Bus front end
    wire wr_stb;
    wire [15:0] wr_addr;
    wire [7:0] wr_data;
    wire wr_lane;
    wire wr_hit;
    wire rd_stb;
    wire [15:0] rd_addr;
    reg [7:0] rd_data;
    wire rd_hit;
    wire [2:0] wr_sel;
    wire [2:0] rd_sel;

    // Register storage
    reg [6:0] seg_first_reg;
    reg [6:0] seg_second_reg;
    reg [7:0] mask_reg;
    reg [4:0] eq_sel_reg;
    reg rail_reg;
    reg [5:0] cable_reg;
    reg [2:0] live_reg;

    // Change flags
    wire loop_code_change_flag;
    wire signal_loss_change_flag;
    wire pattern_lock_change_flag;
    wire status_rd_clr;
    wire [7:0] status_wr_clr;
    wire [7:0] status_word;
    wire [7:0] live_word;
    wire arb_next;

    lusr_axil_slave u_bus (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_lane(wr_lane),
        .wr_hit(wr_hit),
        .rd_stb(rd_stb),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_hit(rd_hit)
    );

    assign wr_sel = reg_sel(wr_addr);
    assign rd_sel = reg_sel(rd_addr);
    assign wr_hit = (wr_sel != SEL_NONE);
    assign rd_hit = (rd_sel != SEL_NONE);

    // Read of the status word clears it; bus stalls are already in rd_stb
    assign status_rd_clr = rd_stb & (rd_sel == SEL_STATUS);
    assign status_wr_clr = (wr_stb & wr_lane & (wr_sel == SEL_STATUS)) ?
        wr_data : 8'h00;

    lusr_change_flag u_loop_flag (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .live(loop_code_detect_state),
        .arm(rail_reg),
        .rd_clr(status_rd_clr),
        .wr_clr(status_wr_clr[`LUSR_BIT_LOOP]),
        .flag_reg(loop_code_change_flag)
    );

    lusr_change_flag u_los_flag (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .live(signal_loss_state),
        .arm(rail_reg),
        .rd_clr(status_rd_clr),
        .wr_clr(status_wr_clr[`LUSR_BIT_LOS]),
        .flag_reg(signal_loss_change_flag)
    );

    lusr_change_flag u_pat_flag (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .live(pattern_lock_state),
        .arm(rail_reg),
        .rd_clr(status_rd_clr),
        .wr_clr(status_wr_clr[`LUSR_BIT_PAT]),
        .flag_reg(pattern_lock_change_flag)
    );

    // Unused bit 2 is tied low
    assign status_word = {
        4'h0,
        loop_code_change_flag,
        1'b0,
        signal_loss_change_flag,
        pattern_lock_change_flag
    };

    assign live_word = {4'h0, live_reg[2], 1'b0, live_reg[1], live_reg[0]};

    // Enable bits share the status layout; only the flag bits exist
    // Held off until the framer copy of the rail select agrees
    assign irq = single_rail_sel & rail_reg & |(status_word & mask_reg);

    // Readback mux
    always @* begin
        case (rd_sel)
            SEL_STATUS: rd_data = status_word;
            SEL_CABLE: rd_data = {2'b00, cable_reg};
            SEL_SEG1: rd_data = {1'b0, seg_first_reg};
            SEL_SEG2: rd_data = {1'b0, seg_second_reg};
            SEL_MASK: rd_data = mask_reg;
            SEL_CTRL: rd_data = {2'b00, eq_sel_reg, rail_reg};
            SEL_LIVE: rd_data = live_word;
            default: rd_data = 8'h00;
        endcase
    end

    // Software-written registers
    always @(posedge core_clk) begin
        if (sys_rst) begin
            seg_first_reg <= `LUSR_RST_SEG;
            seg_second_reg <= `LUSR_RST_SEG;
            mask_reg <= `LUSR_RST_MASK;
            eq_sel_reg <= `LUSR_RST_EQ;
            rail_reg <= 1'b0;
        end else if (clk_en && wr_stb && wr_lane) begin
            case (wr_sel)
                SEL_SEG1: begin
                    seg_first_reg <= wr_data[6:0];
                end
                SEL_SEG2: begin
                    seg_second_reg <= wr_data[6:0];
                end
                SEL_MASK: begin
                    mask_reg <= wr_data & status_mask(1'b0);
                end
                SEL_CTRL: begin
                    eq_sel_reg <= wr_data[`LUSR_CTRL_EQ_HI:`LUSR_CTRL_EQ_LO];
                    rail_reg <= wr_data[`LUSR_CTRL_RAIL];
                end
                default: begin
                    rail_reg <= rail_reg;
                end
            endcase
        end
    end

    // Only the implemented flag positions can be enabled
    function [7:0] status_mask;
        input dummy;
        begin
            status_mask = 8'h00;
            status_mask[`LUSR_BIT_LOOP] = 1'b1;
            status_mask[`LUSR_BIT_LOS] = 1'b1;
            status_mask[`LUSR_BIT_PAT] = 1'b1;
        end
    endfunction

    // Hardware-fed readouts
    always @(posedge core_clk) begin
        if (sys_rst) begin
            cable_reg <= `LUSR_RST_CABLE;
            live_reg <= 3'b000;
        end else if (clk_en) begin
            cable_reg <= cable_attenuation_code;
            // Live status only meaningful in single-rail mode
            if (rail_reg) begin
                live_reg <= {loop_code_detect_state, signal_loss_state,
                    pattern_lock_state};
            end else begin
                live_reg <= 3'b000;
            end
        end
    end

    // Pulse shaping outputs follow the segments only in arbitrary mode
    assign arb_next = (eq_sel_reg == `LUSR_EQ_ARB_CODE);

    always @(posedge core_clk) begin
        if (sys_rst) begin
            arb_mode_active <= 1'b0;
            pulse_amplitude_first <= 8'h00;
            pulse_amplitude_second <= 8'h00;
            equalizer_select_field <= `LUSR_RST_EQ;
            single_rail_sel <= 1'b0;
        end else if (clk_en) begin
            arb_mode_active <= arb_next;
            equalizer_select_field <= eq_sel_reg;
            single_rail_sel <= rail_reg;
            if (arb_next) begin
                pulse_amplitude_first <= sm_to_twos(seg_first_reg);
                pulse_amplitude_second <= sm_to_twos(seg_second_reg);
            end else begin
                pulse_amplitude_first <= 8'h00;
                pulse_amplitude_second <= 8'h00;
            end
        end
    end
endmodule // lusr_regs
`default_nettype wire

// ---- tb/lusr_regs_assertions.sv ----
// Purpose: Port-level checker for the line unit status and shape slice.
// Assumes: Handshakes only count while clk_en is high.
// Notes:   Bound into every lusr_regs instance.
`timescale 1ns/10ps
`default_nettype none
`include "lusr_map.vh"
module lusr_regs_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Line side
    input wire logic [5:0] cable_attenuation_code,
    input wire logic arb_mode_active,
    input wire logic [7:0] pulse_amplitude_first,
    input wire logic [7:0] pulse_amplitude_second,
    input wire logic [4:0] equalizer_select_field,
    input wire logic single_rail_sel,
    input wire logic irq
);
    localparam logic [15:0] A_ST = {`LUSR_IDX_STATUS, 2'b00};
    localparam logic [15:0] A_CB = {`LUSR_IDX_CABLE, 2'b00};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence ar_take;
        clk_en && s_axi_arvalid && s_axi_arready;
    endsequence
    sequence wr_take;
        clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_read_answer: assert property (ar_take |=> s_axi_rvalid)
        else $error("read not answered one cycle after address");
    a_write_answer: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not two cycles after handshake");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped or changed while stalled");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped or changed while stalled");
    a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address accepted while a read answer waits");
    a_status_unused: assert property (ar_take ##0 (s_axi_araddr == A_ST) |=>
        s_axi_rdata[31:4] == 28'h0 && !s_axi_rdata[2])
        else $error("unused status bit reads nonzero");
    a_cable_code: assert property (ar_take ##0 (s_axi_araddr == A_CB) ##0
        ($stable(cable_attenuation_code) && !$past(sys_rst)) |=>
        s_axi_rdata == {26'h0, $past(cable_attenuation_code)})
        else $error("cable code readout wrong");
    a_irq_needs_rail: assert property (irq |-> single_rail_sel)
        else $error("interrupt while single rail is off");
    a_arb_entry: assert property ($rose(arb_mode_active) |->
        equalizer_select_field == `LUSR_EQ_ARB_CODE)
        else $error("arbitrary mode without its select code");
    a_pulse_quiet: assert property (!arb_mode_active && !$past(arb_mode_active) |->
        pulse_amplitude_first == 8'h00 && pulse_amplitude_second == 8'h00)
        else $error("pulse segment driven outside arbitrary mode");
endmodule // lusr_regs_checker
bind lusr_regs lusr_regs_checker u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cable_attenuation_code(cable_attenuation_code),
    .arb_mode_active(arb_mode_active), .pulse_amplitude_first(pulse_amplitude_first),
    .pulse_amplitude_second(pulse_amplitude_second),
    .equalizer_select_field(equalizer_select_field),
    .single_rail_sel(single_rail_sel), .irq(irq));
`default_nettype wire

// ---- tb/test_lusr_regs.sv ----
// Purpose: Self-checking bench for lusr_regs over AXI4-Lite.
// Assumes: clk_en high except for one frozen stretch; live inputs driven by the bench.
// Notes:   Expected values come from the register map and rules.
`timescale 1ns/10ps
`default_nettype none
`include "lusr_map.vh"
module test_lusr_regs;
    localparam logic [15:0] A_ST = {`LUSR_IDX_STATUS, 2'b00};
    localparam logic [15:0] A_CB = {`LUSR_IDX_CABLE, 2'b00};
    localparam logic [15:0] A_S1 = {`LUSR_IDX_SEG1, 2'b00};
    localparam logic [15:0] A_S2 = {`LUSR_IDX_SEG2, 2'b00};
    localparam logic [15:0] A_MK = {`LUSR_IDX_MASK, 2'b00};
    localparam logic [15:0] A_CT = {`LUSR_IDX_CTRL, 2'b00};
    localparam logic [15:0] A_LV = {`LUSR_IDX_LIVE, 2'b00};
    localparam logic [31:0] ARB_ON = {26'h0, 1'b1, `LUSR_EQ_ARB_CODE};
    localparam logic [1:0] OK = `LUSR_RESP_OKAY;
    localparam logic [1:0] BAD = `LUSR_RESP_SLVERR;
    logic core_clk, sys_rst = 1'b1, clk_en = 1'b1;
    logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic [3:0] live = 4'h0;
    logic [5:0] cable_attenuation_code = 6'h00;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire arb_mode_active, single_rail_sel, irq;
    wire [7:0] pulse_amplitude_first, pulse_amplitude_second;
    wire [4:0] equalizer_select_field;
    int err_count = 0;
    int comparisons = 0;
    logic [6:0] tbl [4] = '{7'h45, 7'h05, 7'h40, 7'h7f};

    lusr_regs dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .loop_code_detect_state(live[3]), .signal_loss_state(live[1]),
        .pattern_lock_state(live[0]), .cable_attenuation_code(cable_attenuation_code),
        .arb_mode_active(arb_mode_active), .pulse_amplitude_first(pulse_amplitude_first),
        .pulse_amplitude_second(pulse_amplitude_second),
        .equalizer_select_field(equalizer_select_field),
        .single_rail_sel(single_rail_sel), .irq(irq));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    function automatic logic [7:0] sm(input logic [6:0] v);
        sm = v[6] ? -{2'b00, v[5:0]} : {2'b00, v[5:0]};
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                chk({30'h0, s_axi_bresp}, {30'h0, er});
                break;
            end
        end
    endtask

    // Optional toggle of pattern lock lands in the read's handshake cycle
    task automatic rd(input logic [15:0] a, input logic t, input logic [7:0] e,
                      input logic [1:0] er);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        if (t) live[0] <= ~live[0];
        forever begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                chk(s_axi_rdata, {24'h0, e});
                chk({30'h0, s_axi_rresp}, {30'h0, er});
                break;
            end
        end
    endtask

    task automatic flip(input int b);
        @(posedge core_clk);
        live[b] <= ~live[b];
        repeat (3) @(posedge core_clk);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        end_of_test;
    end

    initial begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(A_CB, 0, 8'h00, OK);
        rd(A_S1, 0, 8'h00, OK);
        rd(A_S2, 0, 8'h00, OK);
        rd(A_ST, 0, 8'h00, OK);
        rd(A_MK, 0, 8'h00, OK);
        rd(16'h3c28, 0, 8'h00, BAD);
        wr(16'h3c28, 8'h5a, BAD);
        cable_attenuation_code <= 6'h2b;
        wr(A_CB, 8'h00, OK);
        rd(A_CB, 0, 8'h2b, OK);
        wr(A_S1, 8'hff, OK);
        rd(A_S1, 0, 8'h7f, OK);
        wr(A_S2, 8'hff, OK);
        rd(A_S2, 0, 8'h7f, OK);
        wr(A_CT, {`LUSR_EQ_ARB_CODE, 1'b1}, OK);
        for (int i = 0; i < 4; i++) begin
            wr(A_S1, {1'b0, tbl[i]}, OK);
            wr(A_S2, {1'b0, tbl[i] ^ 7'h40}, OK);
            repeat (2) @(posedge core_clk);
            chk({24'h0, pulse_amplitude_first}, {24'h0, sm(tbl[i])});
            chk({24'h0, pulse_amplitude_second}, {24'h0, sm(tbl[i] ^ 7'h40)});
        end
        chk({31'h0, single_rail_sel}, 32'h1);
        chk({26'h0, arb_mode_active, equalizer_select_field}, ARB_ON);
        wr(A_CT, 8'h01, OK);
        repeat (2) @(posedge core_clk);
        chk({23'h0, arb_mode_active, pulse_amplitude_first}, 32'h0);
        wr(A_MK, 8'hff, OK);
        rd(A_MK, 0, 8'h0b, OK);
        rd(A_ST, 0, 8'h00, OK);
        for (int b = 0; b < 4; b++) begin
            if (b != 2) begin
                flip(b);
                chk({31'h0, irq}, 32'h1);
                rd(A_ST, 0, 8'h01 << b, OK);
                rd(A_ST, 0, 8'h00, OK);
                chk({31'h0, irq}, 32'h0);
            end
        end
        rd(A_LV, 0, 8'h0b, OK);
        flip(1);
        flip(1);
        rd(A_ST, 0, 8'h02, OK);
        flip(3);
        wr(A_ST, 8'h08, OK);
        rd(A_ST, 0, 8'h00, OK);
        rd(A_ST, 1, 8'h00, OK);
        rd(A_ST, 0, 8'h01, OK);
        // Frozen core must not see the change until enable returns
        clk_en <= 1'b0;
        flip(3);
        chk({31'h0, irq}, 32'h0);
        clk_en <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        rd(A_ST, 0, 8'h08, OK);
        wr(A_MK, 8'h00, OK);
        flip(0);
        chk({31'h0, irq}, 32'h0);
        rd(A_ST, 0, 8'h01, OK);
        wr(A_MK, 8'h0b, OK);
        wr(A_CT, 8'h00, OK);
        flip(0);
        flip(1);
        flip(3);
        chk({31'h0, irq}, 32'h0);
        rd(A_ST, 0, 8'h00, OK);
        rd(A_LV, 0, 8'h00, OK);
        end_of_test;
    end
endmodule // test_lusr_regs
`default_nettype wire
